// file: rtl/watchdog_timer_unit.sv
module watchdog_timer_unit
	import watchdog_timer_unit_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic sys_reset_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic page_p_in,
	input wire logic system_flag_irq_enable_in,
	input wire logic slow_internal_osc_in,
	input wire logic external_clock_in,
	input wire logic idle_mode_in,
	input wire logic power_down_in,
	input wire logic nonstop_hw_option_in,
	input wire logic reset_enable_hw_option_in,
	output logic [7:0] sfr_rdata_out,
	output logic irq_out,
	output logic system_reset_out,
	output logic wakeup_out
);

	localparam int SYNC_CHANNELS = 2;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] watchdog_control, clock_control_three, prescaler, counter;
	logic dog_overflow_flag, dog_flag_irq_enable, options_loaded;
	logic [3:0] system_clk_div;
	logic wr_control, wr_clock_three, wr_flags, wr_irq_enables, counter_clear;
	logic [7:0] next_control, read_mux, prescale_mask;
	logic [SYNC_CHANNELS-1:0] pin_raw, sync_a, sync_b, sync_c, pin_level, pin_rise;
	logic [1:0] source_sel;
	logic source_tick, count_allowed, prescale_tick, overflow_event;

	assign wr_control = sfr_wr_in && (sfr_addr_in == ADDR_WATCHDOG_CONTROL);
	assign wr_clock_three = sfr_wr_in && page_p_in
		&& (sfr_addr_in == ADDR_CLOCK_CONTROL_THREE);
	assign wr_flags = sfr_wr_in && (sfr_addr_in == ADDR_POWER_CONTROL_ONE);
	assign wr_irq_enables = sfr_wr_in && (sfr_addr_in == ADDR_SYSTEM_FLAG_IRQ_ENABLES);
	assign counter_clear = wr_control && sfr_wdata_in[WC_COUNTER_CLEAR];
	assign source_sel = clock_control_three[CC3_CLOCK_SOURCE_HI:CC3_CLOCK_SOURCE_LO];

	// ----------------------------------------------------------------
	// Control register write
	// ----------------------------------------------------------------
	always_comb
	begin
		// Run, non-stop and reset enable only clear through the privileged page
		if (page_p_in)
			next_control = sfr_wdata_in & ~(8'h01 << WC_COUNTER_CLEAR);
		else
			next_control = (watchdog_control & WC_SET_ONCE_MASK)
				| (sfr_wdata_in & WC_SET_ONCE_MASK)
				| (sfr_wdata_in & WC_PLAIN_MASK);
	end

	// Only rst_n_in (power-on) reaches this register; system resets do not
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			watchdog_control <= RST_WATCHDOG_CONTROL;
			options_loaded <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (!options_loaded)
			begin
				// Straps are taken after release, never under the reset itself
				options_loaded <= 1'b1;
				watchdog_control[WC_OVERFLOW_RESET_ENABLE] <= reset_enable_hw_option_in;
				watchdog_control[WC_NONSTOP_COUNT] <= nonstop_hw_option_in;
			end
			else if (wr_control)
				watchdog_control <= next_control;
		end
	end

	// Clock source defaults to the slow oscillator
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			clock_control_three <= RST_CLOCK_CONTROL_THREE;
		else if (clk_en_in && wr_clock_three)
			clock_control_three <= sfr_wdata_in & CC3_WRITABLE_MASK;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			dog_flag_irq_enable <= 1'b0;
		else if (clk_en_in && wr_irq_enables)
			dog_flag_irq_enable <= sfr_wdata_in[SYSTEM_FLAG_IRQ_ENABLES_DOG_FLAG_IRQ_ENABLE];
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	assign pin_raw = {external_clock_in, slow_internal_osc_in};

	// Three stages plus agreement filter cost roughly four system clocks
	// of delay on the slow path, well inside its 120 us budget
	generate
		for (genvar i = 0; i < SYNC_CHANNELS; i++)
		begin : g_sync
			always_ff @(posedge clk_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
				begin
					sync_a[i] <= 1'b0;
					sync_b[i] <= 1'b0;
					sync_c[i] <= 1'b0;
					pin_level[i] <= 1'b0;
					pin_rise[i] <= 1'b0;
				end
				else if (clk_en_in)
				begin
					sync_a[i] <= pin_raw[i];
					sync_b[i] <= sync_a[i];
					sync_c[i] <= sync_b[i];
					pin_rise[i] <= 1'b0;
					if ((sync_b[i] == sync_c[i]) && (sync_c[i] != pin_level[i]))
					begin
						pin_level[i] <= sync_c[i];
						pin_rise[i] <= sync_c[i];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Source select and gating
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			system_clk_div <= 4'h0;
		else if (clk_en_in)
			system_clk_div <= (system_clk_div == SYSTEM_CLK_DIVIDE_LAST) ? 4'h0 : system_clk_div + 4'h1;
	end

	always_comb
	begin
		case (source_sel)
			SRC_SLOW_OSC: source_tick = pin_rise[0];
			SRC_EXTERNAL: source_tick = pin_rise[1];
			SRC_SYSTEM_CLK_DIV12: source_tick = (system_clk_div == SYSTEM_CLK_DIVIDE_LAST);
			default: source_tick = 1'b0;
		endcase
	end

	always_comb
	begin
		count_allowed = watchdog_control[WC_DOG_RUN_ENABLE];
		if (power_down_in)
		begin
			// Watch mode needs a clock that survives power-down
			count_allowed = count_allowed && watchdog_control[WC_NONSTOP_COUNT]
				&& ((source_sel == SRC_SLOW_OSC) || (source_sel == SRC_EXTERNAL));
		end
		else if (idle_mode_in)
		begin
			count_allowed = count_allowed && (watchdog_control[WC_IDLE_COUNT_ENABLE]
				|| nonstop_hw_option_in);
		end
	end

	// ----------------------------------------------------------------
	// Prescaler and counter
	// ----------------------------------------------------------------
	assign prescale_mask = 8'((9'h002 << watchdog_control[WC_PRESCALE_SEL_HI:WC_PRESCALE_SEL_LO])
		- 9'h001);
	assign prescale_tick = source_tick && count_allowed
		&& ((prescaler & prescale_mask) == prescale_mask);
	assign overflow_event = prescale_tick
		&& (clock_control_three[CC3_OVERFLOW_SOURCE_SEL] ? counter[0]
		: (counter == 8'hff));

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			prescaler <= 8'h00;
			counter <= 8'h00;
		end
		else if (clk_en_in)
		begin
			if (counter_clear || sys_reset_in)
			begin
				prescaler <= 8'h00;
				counter <= 8'h00;
			end
			else if (source_tick && count_allowed)
			begin
				prescaler <= prescaler + 8'h01;
				if (prescale_tick)
					counter <= counter + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Flag, interrupt, reset and wake
	// ----------------------------------------------------------------
	// A fresh overflow beats a clear in the same cycle
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			dog_overflow_flag <= 1'b0;
		else if (clk_en_in && overflow_event)
			dog_overflow_flag <= 1'b1;
		else if (clk_en_in && wr_flags && sfr_wdata_in[PC1_DOG_OVERFLOW_FLAG])
			dog_overflow_flag <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_out <= 1'b0;
		else if (clk_en_in)
			irq_out <= dog_overflow_flag && dog_flag_irq_enable
				&& system_flag_irq_enable_in;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			system_reset_out <= 1'b0;
			wakeup_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			system_reset_out <= overflow_event
				&& watchdog_control[WC_OVERFLOW_RESET_ENABLE];
			wakeup_out <= overflow_event && power_down_in;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb
	begin
		case (sfr_addr_in)
			ADDR_WATCHDOG_CONTROL: read_mux = watchdog_control;
			ADDR_CLOCK_CONTROL_THREE: read_mux = clock_control_three;
			ADDR_POWER_CONTROL_ONE: read_mux = {7'h00, dog_overflow_flag};
			ADDR_SYSTEM_FLAG_IRQ_ENABLES: read_mux = {7'h00, dog_flag_irq_enable};
			default: read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			sfr_rdata_out <= 8'h00;
		else if (clk_en_in && sfr_rd_in)
			sfr_rdata_out <= read_mux;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_clear_zeroes;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && (counter_clear || sys_reset_in)
		|=> (counter == 8'h00) && (prescaler == 8'h00);
	endproperty
	a_clear_zeroes: assert property (p_clear_zeroes)
		else $error("counter not zeroed by clear write");

	property p_run_sticks;
		@(posedge clk_in) disable iff (!rst_n_in)
		watchdog_control[WC_DOG_RUN_ENABLE] && !(clk_en_in && wr_control && page_p_in)
		|=> watchdog_control[WC_DOG_RUN_ENABLE];
	endproperty
	a_run_sticks: assert property (p_run_sticks)
		else $error("run enable cleared outside privileged page");

	property p_set_once;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && options_loaded && wr_control && !page_p_in
		|=> (watchdog_control & WC_SET_ONCE_MASK)
		== (($past(watchdog_control) | $past(sfr_wdata_in)) & WC_SET_ONCE_MASK);
	endproperty
	a_set_once: assert property (p_set_once)
		else $error("set-once bits wrong after normal write");

	property p_flag_set;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && overflow_event |=> dog_overflow_flag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("overflow did not set flag");

	property p_irq_gate;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && !system_flag_irq_enable_in |=> !irq_out;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt without system flag enable");

	property p_reset_on_overflow;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && overflow_event && watchdog_control[WC_OVERFLOW_RESET_ENABLE]
		|=> system_reset_out ##1 (!system_reset_out || !$past(clk_en_in)
		|| $past(overflow_event));
	endproperty
	a_reset_on_overflow: assert property (p_reset_on_overflow)
		else $error("overflow reset pulse wrong");

	property p_pd_halt;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && power_down_in && !watchdog_control[WC_NONSTOP_COUNT] && !counter_clear
		&& !sys_reset_in |=> $stable(counter);
	endproperty
	a_pd_halt: assert property (p_pd_halt)
		else $error("counter moved in power-down without non-stop");

	property p_idle_halt;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && idle_mode_in && !power_down_in && !nonstop_hw_option_in
		&& !watchdog_control[WC_IDLE_COUNT_ENABLE] && !counter_clear && !sys_reset_in
		|=> $stable(counter) && $stable(prescaler);
	endproperty
	a_idle_halt: assert property (p_idle_halt)
		else $error("counter moved in idle without idle count");

	property p_div12;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && source_tick && (source_sel == SRC_SYSTEM_CLK_DIV12)
		|=> !(clk_en_in && source_tick && (source_sel == SRC_SYSTEM_CLK_DIV12));
	endproperty
	a_div12: assert property (p_div12)
		else $error("divide-by-12 tick repeated");

endmodule : watchdog_timer_unit

// file: rtl/watchdog_timer_unit_pkg.sv
package watchdog_timer_unit_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CLOCK_CONTROL_THREE = 8'h41;
	localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'he1;
	localparam logic [7:0] ADDR_POWER_CONTROL_ONE = 8'h97;
	localparam logic [7:0] ADDR_SYSTEM_FLAG_IRQ_ENABLES = 8'h8e;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CLOCK_CONTROL_THREE = 8'h00;
	localparam logic [7:0] RST_WATCHDOG_CONTROL = 8'h07;

	// ----------------------------------------------------------------
	// Field positions, watchdog_control
	// ----------------------------------------------------------------
	localparam int WC_OVERFLOW_RESET_ENABLE = 7;
	localparam int WC_NONSTOP_COUNT = 6;
	localparam int WC_DOG_RUN_ENABLE = 5;
	localparam int WC_COUNTER_CLEAR = 4;
	localparam int WC_IDLE_COUNT_ENABLE = 3;
	localparam int WC_PRESCALE_SEL_HI = 2;
	localparam int WC_PRESCALE_SEL_LO = 0;
	// Bits 7..5: write-one-only outside the privileged page
	localparam logic [7:0] WC_SET_ONCE_MASK = 8'he0;
	localparam logic [7:0] WC_PLAIN_MASK = 8'h0f;

	// ----------------------------------------------------------------
	// Field positions, clock_control_three
	// ----------------------------------------------------------------
	localparam int CC3_CLOCK_SOURCE_HI = 7;
	localparam int CC3_CLOCK_SOURCE_LO = 6;
	localparam int CC3_OVERFLOW_SOURCE_SEL = 4;
	localparam logic [7:0] CC3_WRITABLE_MASK = 8'hfc;

	// Flag and enable bit positions
	localparam int PC1_DOG_OVERFLOW_FLAG = 0;
	localparam int SYSTEM_FLAG_IRQ_ENABLES_DOG_FLAG_IRQ_ENABLE = 0;

	// ----------------------------------------------------------------
	// Clock source codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_SLOW_OSC = 2'h0,
		SRC_EXTERNAL = 2'h1,
		SRC_SYSTEM_CLK_DIV12 = 2'h2,
		SRC_RESERVED = 2'h3
	} clock_source_e;

	localparam logic [3:0] SYSTEM_CLK_DIVIDE = 4'hc;
	localparam logic [3:0] SYSTEM_CLK_DIVIDE_LAST = SYSTEM_CLK_DIVIDE - 4'h1;

	// ----------------------------------------------------------------
	// Timing figures
	// ----------------------------------------------------------------
	localparam int SLOW_OSC_KHZ = 32;
	localparam int PERIOD_MIN_MS = 16;
	localparam int PERIOD_MAX_MS = 2048;
	localparam int SLOW_PATH_LATENCY_US = 120;
	localparam int LATENCY_MARGIN_BELOW_MS = 12;

endpackage : watchdog_timer_unit_pkg

// file: dv/watchdog_timer_unit_tb_top.sv
module watchdog_timer_unit_tb_top
	import watchdog_timer_unit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_in, rst_n_in, clk_en_in, sys_reset_in, sfr_wr_in, sfr_rd_in, page_p_in;
	logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
	logic system_flag_irq_enable_in, idle_mode_in, power_down_in;
	logic nonstop_hw_option_in, reset_enable_hw_option_in;
	logic slow_internal_osc_in = 1'b0;
	logic external_clock_in = 1'b0;
	logic irq_out, system_reset_out, wakeup_out;
	logic rd_taken = 1'b0;
	logic [7:0] exp_q[$];
	int err_total, num_checks, cyc, osc_n = 0;
	int per[3] = '{8, 6, 12};

	watchdog_timer_unit uut (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.sys_reset_in(sys_reset_in),
		.sfr_addr_in(sfr_addr_in),
		.sfr_wr_in(sfr_wr_in),
		.sfr_rd_in(sfr_rd_in),
		.sfr_wdata_in(sfr_wdata_in),
		.page_p_in(page_p_in),
		.system_flag_irq_enable_in(system_flag_irq_enable_in),
		.slow_internal_osc_in(slow_internal_osc_in),
		.external_clock_in(external_clock_in),
		.idle_mode_in(idle_mode_in),
		.power_down_in(power_down_in),
		.nonstop_hw_option_in(nonstop_hw_option_in),
		.reset_enable_hw_option_in(reset_enable_hw_option_in),
		.sfr_rdata_out(sfr_rdata_out),
		.irq_out(irq_out),
		.system_reset_out(system_reset_out),
		.wakeup_out(wakeup_out)
	);

	// ----------------------------------------------------------------
	// Clocks and oscillator pins
	// ----------------------------------------------------------------
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	// Pin levels last 4 and 3 cycles, above the 2-cycle filter minimum
	always @(negedge clk_in)
	begin
		osc_n <= osc_n + 1;
		if (osc_n % 4 == 3)
			slow_internal_osc_in <= ~slow_internal_osc_in;
		if (osc_n % 3 == 2)
			external_clock_in <= ~external_clock_in;
	end

	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			err_total++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// Read monitor: oldest noted value against registered read data
	// ----------------------------------------------------------------
	always @(posedge clk_in)
		rd_taken <= sfr_rd_in & clk_en_in & rst_n_in;

	always @(negedge clk_in)
		if (rd_taken === 1'b1)
			check("sfr_rdata_out", sfr_rdata_out, exp_q.pop_front());

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	// Each access starts on a fresh edge, so strobes never toggle twice at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic p);
		@(negedge clk_in);
		sfr_addr_in = a;
		sfr_wdata_in = d;
		page_p_in = p;
		sfr_wr_in = 1'b1;
		@(negedge clk_in);
		sfr_wr_in = 1'b0;
		page_p_in = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_in);
		sfr_addr_in = a;
		sfr_rd_in = 1'b1;
		exp_q.push_back(e);
		@(negedge clk_in);
		sfr_rd_in = 1'b0;
	endtask : rd

	task automatic watch(input int k, input int n, output int c);
		c = 0;
		repeat (n)
		begin
			@(negedge clk_in);
			if ((k ? wakeup_out : system_reset_out) === 1'b1)
				c++;
		end
	endtask : watch

	// First intervals after a reconfiguration are irregular; keep the last
	task automatic gap(input int lim, output int n);
		repeat (3)
		begin
			n = 0;
			do
			begin
				@(negedge clk_in);
				n++;
			end while (system_reset_out !== 1'b1 && n < lim);
		end
	endtask : gap

	task automatic done(input string t);
		$display("test %s done", t);
	endtask : done

	task automatic stop_test();
		repeat (2) @(negedge clk_in);
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		int n;
		int c;
		int tot;
		logic [7:0] v;
		rst_n_in = 1'b0;
		clk_en_in = 1'b1;
		sys_reset_in = 1'b0;
		sfr_addr_in = 8'h00;
		sfr_wdata_in = 8'h00;
		sfr_wr_in = 1'b0;
		sfr_rd_in = 1'b0;
		page_p_in = 1'b0;
		system_flag_irq_enable_in = 1'b0;
		idle_mode_in = 1'b0;
		power_down_in = 1'b0;
		nonstop_hw_option_in = 1'b0;
		reset_enable_hw_option_in = 1'b0;
		err_total = 0;
		num_checks = 0;
		cyc = 0;
		void'($urandom(34));
		repeat (8) @(negedge clk_in);
		rst_n_in = 1'b1;
		rd(ADDR_WATCHDOG_CONTROL, RST_WATCHDOG_CONTROL);
		rd(ADDR_CLOCK_CONTROL_THREE, RST_CLOCK_CONTROL_THREE);
		rd(ADDR_POWER_CONTROL_ONE, 8'h00);
		rd(ADDR_SYSTEM_FLAG_IRQ_ENABLES, 8'h00);
		rd(8'h55, 8'h00);
		done("reset values");
		wr(ADDR_CLOCK_CONTROL_THREE, 8'hff, 1'b0);
		rd(ADDR_CLOCK_CONTROL_THREE, 8'h00);
		v = 8'($urandom) & 8'h2c;
		wr(ADDR_CLOCK_CONTROL_THREE, v, 1'b1);
		rd(ADDR_CLOCK_CONTROL_THREE, v);
		wr(ADDR_WATCHDOG_CONTROL, 8'h2b, 1'b0);
		rd(ADDR_WATCHDOG_CONTROL, 8'h2b);
		wr(ADDR_WATCHDOG_CONTROL, 8'h03, 1'b0);
		rd(ADDR_WATCHDOG_CONTROL, 8'h23);
		wr(ADDR_WATCHDOG_CONTROL, 8'h17, 1'b1);
		rd(ADDR_WATCHDOG_CONTROL, 8'h07);
		done("register access");
		wr(ADDR_SYSTEM_FLAG_IRQ_ENABLES, 8'h01, 1'b0);
		system_flag_irq_enable_in = 1'b1;
		for (int s = 0; s < 3; s++)
			for (int p = 0; p < 2; p++)
			begin
				wr(ADDR_CLOCK_CONTROL_THREE, {s[1:0], 6'h10}, 1'b1);
				wr(ADDR_WATCHDOG_CONTROL, 8'ha0 | 8'(p), 1'b0);
				gap(2000, n);
				check("overflow gap", 16'(n), 16'(per[s] * (4 << p)));
			end
		wr(ADDR_CLOCK_CONTROL_THREE, 8'h40, 1'b1);
		wr(ADDR_WATCHDOG_CONTROL, 8'ha0, 1'b0);
		gap(8000, n);
		check("full counter gap", 16'(n), 16'(6 * 256 * 2));
		done("overflow rates");
		rd(ADDR_POWER_CONTROL_ONE, 8'h01);
		check("irq_out", irq_out, 1'b1);
		system_flag_irq_enable_in = 1'b0;
		repeat (3) @(negedge clk_in);
		check("irq_out", irq_out, 1'b0);
		system_flag_irq_enable_in = 1'b1;
		wr(ADDR_WATCHDOG_CONTROL, 8'h00, 1'b1);
		wr(ADDR_POWER_CONTROL_ONE, 8'h00, 1'b0);
		rd(ADDR_POWER_CONTROL_ONE, 8'h01);
		wr(ADDR_POWER_CONTROL_ONE, 8'h01, 1'b0);
		rd(ADDR_POWER_CONTROL_ONE, 8'h00);
		repeat (3) @(negedge clk_in);
		check("irq_out", irq_out, 1'b0);
		done("flag and interrupt");
		wr(ADDR_CLOCK_CONTROL_THREE, 8'h90, 1'b1);
		wr(ADDR_WATCHDOG_CONTROL, 8'hb3, 1'b0);
		tot = 0;
		repeat (10)
		begin
			wr(ADDR_WATCHDOG_CONTROL, 8'h13, 1'b0);
			watch(0, 60, c);
			tot += c;
		end
		check("resets while cleared", 16'(tot), 16'h0);
		watch(0, 400, c);
		check("resets after clearing stops", 16'(c), 16'h1);
		done("counter clear");
		wr(ADDR_WATCHDOG_CONTROL, 8'ha0, 1'b0);
		idle_mode_in = 1'b1;
		watch(0, 200, c);
		check("idle count off", 16'(c), 16'h0);
		wr(ADDR_WATCHDOG_CONTROL, 8'h08, 1'b0);
		watch(0, 200, c);
		check("idle count on", 16'(c > 0), 16'h1);
		idle_mode_in = 1'b0;
		power_down_in = 1'b1;
		watch(1, 200, c);
		check("power-down halted", 16'(c), 16'h0);
		wr(ADDR_WATCHDOG_CONTROL, 8'h40, 1'b0);
		watch(1, 200, c);
		check("power-down fast source", 16'(c), 16'h0);
		wr(ADDR_CLOCK_CONTROL_THREE, 8'h10, 1'b1);
		watch(1, 200, c);
		check("wakeup slow source", 16'(c > 0), 16'h1);
		wr(ADDR_CLOCK_CONTROL_THREE, 8'h50, 1'b1);
		watch(1, 200, c);
		check("wakeup pin source", 16'(c > 0), 16'h1);
		power_down_in = 1'b0;
		done("idle and power-down");
		sys_reset_in = 1'b1;
		@(negedge clk_in);
		sys_reset_in = 1'b0;
		rd(ADDR_WATCHDOG_CONTROL, 8'he0);
		rd(ADDR_CLOCK_CONTROL_THREE, 8'h50);
		clk_en_in = 1'b0;
		wr(ADDR_SYSTEM_FLAG_IRQ_ENABLES, 8'h00, 1'b0);
		clk_en_in = 1'b1;
		rd(ADDR_SYSTEM_FLAG_IRQ_ENABLES, 8'h01);
		done("system reset and freeze");
		// Second power-on with both straps set
		rst_n_in = 1'b0;
		nonstop_hw_option_in = 1'b1;
		reset_enable_hw_option_in = 1'b1;
		repeat (8) @(negedge clk_in);
		rst_n_in = 1'b1;
		rd(ADDR_WATCHDOG_CONTROL, 8'hc7);
		wr(ADDR_CLOCK_CONTROL_THREE, 8'h90, 1'b1);
		wr(ADDR_WATCHDOG_CONTROL, 8'h20, 1'b0);
		idle_mode_in = 1'b1;
		watch(0, 200, c);
		check("strap idle count", 16'(c > 0), 16'h1);
		idle_mode_in = 1'b0;
		done("hardware options");
		stop_test();
	end

endmodule : watchdog_timer_unit_tb_top
